//--- common/fxd_defines.svh
// Notes on behaviour
// - Invalid operand sets status bit 0
// - Control bit 0 masks invalid operation
// - Unmasked invalid: handler, stack and sources kept
// - Unsupported encoding masked: real indefinite result
// - Signaling NaN masked: deliver quiet NaN
// - Masked compare with NaN: codes 111
// - Infinity add/sub conflict masked: real indefinite
// - Inf times zero, inf/inf, 0/0: indefinite
// - Remainder/trig faults: indefinite, condition two cleared
// - Integer store overflow: most negative integer
// - Negative sqrt/log: indefinite; minus zero special
// - Log-plus-one below minus one: indefinite
// - Bad packed BCD store: BCD indefinite
// - Exchange with empty: fill indefinite, then swap
// - Finite by zero divide sets status bit 2
// - Masked divide by zero: signed infinity
// - Masked log zero-divide: opposite-signed infinity
// - Masked extract zero-divide: minus infinity, signed zero
// - Unmasked zero-divide: handler, state kept
// - Denormal use or short load signals; extended not
// - Denormal flag and mask at bit 1
// - Masked denormal: set flag, continue, normalize
// - Unmasked denormal: handler, state kept
`ifndef FXD_DEFINES_SVH
`define FXD_DEFINES_SVH
`define FXD_BIT_INVALID   0
`define FXD_BIT_DENORMAL  1
`define FXD_BIT_ZERODIV   2
`define FXD_BIT_CC0       8
`define FXD_BIT_CC2       10
`define FXD_BIT_CC3       14
`define FXD_EXP_ONES      15'h7fff
`define FXD_EXP_BIAS      15'h3fff
`define FXD_IND_HI        16'hffff
`define FXD_IND_LO        64'hc000_0000_0000_0000
`define FXD_INF_LO        64'h8000_0000_0000_0000
`define FXD_QUIET_BIT     62
`define FXD_BCD_IND       80'hffff_c000_0000_0000_0000
`define FXD_BCD_MAX_EXP   15'h403a
`define FXD_INT16_NEG     64'hffff_ffff_ffff_8000
`define FXD_INT32_NEG     64'hffff_ffff_8000_0000
`define FXD_INT64_NEG     64'h8000_0000_0000_0000
`define FXD_INT16_EXP     15'h400e
`define FXD_INT32_EXP     15'h401e
`define FXD_INT64_EXP     15'h403e
`define FXD_ADDR_CTRL     2'h0
`define FXD_ADDR_STAT     2'h1
`define FXD_ADDR_CAUSE    2'h2
`define FXD_CTRL_RESET    16'h0007
`endif

//--- common/fxd_pkg.sv
package fxd_pkg;
   // Operation codes presented with each request
   typedef enum logic [4:0] {
      FXD_OP_ADD      = 5'h00,
      FXD_OP_SUB      = 5'h01,
      FXD_OP_MUL      = 5'h02,
      FXD_OP_DIV      = 5'h03,
      FXD_OP_RDIV     = 5'h04,
      FXD_OP_COMPARE  = 5'h05,
      FXD_OP_PREM     = 5'h06,
      FXD_OP_TRIG     = 5'h07,
      FXD_OP_ISTORE   = 5'h08,
      FXD_OP_SQRT     = 5'h09,
      FXD_OP_LOG      = 5'h0a,
      FXD_OP_LOGP1    = 5'h0b,
      FXD_OP_BCDSTORE = 5'h0c,
      FXD_OP_EXCHANGE = 5'h0d,
      FXD_OP_EXTRACT  = 5'h0e,
      FXD_OP_LOAD     = 5'h0f
   } fxd_op_type;
   // Load source format
   typedef enum logic [1:0] {
      FXD_FMT_EXT    = 2'h0,
      FXD_FMT_SINGLE = 2'h1,
      FXD_FMT_DOUBLE = 2'h2
   } fxd_fmt_type;
   // Integer store width
   typedef enum logic [1:0] {
      FXD_INT_16 = 2'h0,
      FXD_INT_32 = 2'h1,
      FXD_INT_64 = 2'h2
   } fxd_isz_type;
   // Sequencer states, one-hot
   typedef enum logic [2:0] {
      FXD_ST_IDLE   = 3'b001,
      FXD_ST_RESULT = 3'b010,
      FXD_ST_TRAP   = 3'b100
   } fxd_state_type;
endpackage

//--- hw/fxd_exception_unit.sv
// Implementation choices: strobed register access and the register offsets.
`timescale 1ns/100ps
`include "fxd_defines.svh"
module fxd_exception_unit (
   input  wire logic                 MCLK,
   input  wire logic                 RESETN,
   input  wire logic                 CE,
   input  wire logic                 REQ_VALID,
   input  wire fxd_pkg::fxd_op_type  REQ_OP,
   input  wire fxd_pkg::fxd_fmt_type REQ_FMT,
   input  wire fxd_pkg::fxd_isz_type REQ_ISZ,
   input  wire logic [79:0]          REQ_OPA,
   input  wire logic [79:0]          REQ_OPB,
   input  wire logic                 REQ_EMPTY_A,
   input  wire logic                 REQ_EMPTY_B,
   input  wire logic [1:0]           REG_ADDR,
   input  wire logic [15:0]          REG_WDATA,
   input  wire logic                 REG_WR,
   input  wire logic                 REG_RD,
   output logic [15:0]               REG_RDATA,
   output logic                      RSP_VALID,
   output logic                      RSP_FAULT,
   output logic                      RSP_WRITE_A,
   output logic                      RSP_WRITE_B,
   output logic [79:0]               RSP_RES_A,
   output logic [79:0]               RSP_RES_B,
   output logic                      TRAP,
   output logic [15:0]               STATUS_WORD,
   output logic [15:0]               CONTROL_WORD
);
   import fxd_pkg::*;

   //--------------------------------------------------------------
   // Operand classification
   //--------------------------------------------------------------
   // Field checks used on both operands
   function automatic logic is_zero(input logic [79:0] v);
      is_zero = (v[78:64] == 15'h0000) && (v[63:0] == 64'h0000_0000_0000_0000);
   endfunction
   function automatic logic is_inf(input logic [79:0] v);
      is_inf = (v[78:64] == `FXD_EXP_ONES) && (v[63:0] == `FXD_INF_LO);
   endfunction
   function automatic logic is_nan(input logic [79:0] v);
      is_nan = (v[78:64] == `FXD_EXP_ONES) && v[63] && (v[62:0] != 63'h0);
   endfunction
   function automatic logic is_snan(input logic [79:0] v);
      is_snan = is_nan(v) && !v[`FXD_QUIET_BIT];
   endfunction
   // Integer bit clear with a non-zero exponent is an unsupported encoding
   function automatic logic is_unsup(input logic [79:0] v);
      is_unsup = (v[78:64] != 15'h0000) && !v[63];
   endfunction
   function automatic logic is_denorm(input logic [79:0] v);
      is_denorm = (v[78:64] == 15'h0000) && (v[63:0] != 64'h0000_0000_0000_0000);
   endfunction
   // Signed infinity in extended format
   function automatic logic [79:0] inf_of(input logic s);
      inf_of = {s, `FXD_EXP_ONES, `FXD_INF_LO};
   endfunction

   //--------------------------------------------------------------
   // Registers
   //--------------------------------------------------------------
   fxd_state_type state_ff;      // Sequencer state
   fxd_state_type nxt_state;
   logic [15:0]   ctrl_ff;       // Control word, masks in low bits
   logic [15:0]   stat_ff;       // Status word, sticky flags
   logic [2:0]    cause_ff;      // Faults of the last request
   logic [15:0]   rdata_ff;
   logic          rsp_valid_ff;
   logic          rsp_fault_ff;
   logic          wr_a_ff;
   logic          wr_b_ff;
   logic [79:0]   res_a_ff;
   logic [79:0]   res_b_ff;
   logic          trap_ff;

   //--------------------------------------------------------------
   // Condition detection
   //--------------------------------------------------------------
   wire logic [79:0] ind = {`FXD_IND_HI, `FXD_IND_LO};   // Real indefinite
   wire logic sa = REQ_OPA[79];                          // Operand signs
   wire logic sb = REQ_OPB[79];
   wire logic za = is_zero(REQ_OPA);
   wire logic zb = is_zero(REQ_OPB);
   wire logic ia = is_inf(REQ_OPA);
   wire logic ib = is_inf(REQ_OPB);
   wire logic na = is_nan(REQ_OPA);
   wire logic nb = is_nan(REQ_OPB);
   wire logic snan_any = is_snan(REQ_OPA) || is_snan(REQ_OPB);
   wire logic unsup_any = is_unsup(REQ_OPA) || is_unsup(REQ_OPB);
   wire logic op_is_load = (REQ_OP == FXD_OP_LOAD);
   wire logic op_divide = (REQ_OP == FXD_OP_DIV) || (REQ_OP == FXD_OP_RDIV);
   // Reverse divide swaps the roles: divisor is A
   wire logic divisor_zero = (REQ_OP == FXD_OP_RDIV) ? za : zb;
   wire logic dividend_zero = (REQ_OP == FXD_OP_RDIV) ? zb : za;
   wire logic dividend_inf = (REQ_OP == FXD_OP_RDIV) ? ib : ia;
   wire logic divisor_inf = (REQ_OP == FXD_OP_RDIV) ? ia : ib;
   // Integer store range: biased exponent limit per size
   wire logic [14:0] int_exp = (REQ_ISZ == FXD_INT_16) ? `FXD_INT16_EXP :
                               (REQ_ISZ == FXD_INT_32) ? `FXD_INT32_EXP :
                               `FXD_INT64_EXP;
   wire logic [63:0] int_neg = (REQ_ISZ == FXD_INT_16) ? `FXD_INT16_NEG :
                               (REQ_ISZ == FXD_INT_32) ? `FXD_INT32_NEG :
                               `FXD_INT64_NEG;
   // Magnitude 2^(n-1) fits only when negative with zero fraction
   wire logic int_edge = (REQ_OPA[78:64] == int_exp) && sa &&
                         (REQ_OPA[62:0] == 63'h0);
   wire logic int_ovf = na || ia || ((REQ_OPA[78:64] >= int_exp) && !int_edge);
   // Less than minus one: negative with exponent at least the bias, not exactly -1
   wire logic below_m1 = sa && !na && (REQ_OPA[78:64] >= `FXD_EXP_BIAS) &&
                         !((REQ_OPA[78:64] == `FXD_EXP_BIAS) &&
                           (REQ_OPA[62:0] == 63'h0));
   wire logic neg_nz = sa && !za && !na;

   // Operation-specific invalid arithmetic condition
   logic op_inv;
   always_comb begin
      case (REQ_OP)
         FXD_OP_ADD:      op_inv = ia && ib && (sa != sb);
         FXD_OP_SUB:      op_inv = ia && ib && (sa == sb);
         FXD_OP_MUL:      op_inv = (ia && zb) || (za && ib);
         FXD_OP_DIV,
         FXD_OP_RDIV:     op_inv = (ia && ib) || (za && zb);
         FXD_OP_COMPARE:  op_inv = na || nb;
         FXD_OP_PREM:     op_inv = zb || ia;
         FXD_OP_TRIG:     op_inv = ia;
         FXD_OP_ISTORE:   op_inv = int_ovf;
         FXD_OP_SQRT:     op_inv = neg_nz;
         FXD_OP_LOG:      op_inv = neg_nz;
         FXD_OP_LOGP1:    op_inv = below_m1;
         FXD_OP_BCDSTORE: op_inv = REQ_EMPTY_A || na || ia ||
                                   (REQ_OPA[78:64] > `FXD_BCD_MAX_EXP);
         FXD_OP_EXCHANGE: op_inv = REQ_EMPTY_A || REQ_EMPTY_B;
         default:         op_inv = 1'b0;
      endcase
   end

   // Loads and exchanges are not arithmetic on NaN or encoding grounds
   wire logic arith = !op_is_load && (REQ_OP != FXD_OP_EXCHANGE);
   wire logic inv_det = arith && (unsup_any || snan_any) || op_inv;
   // Finite non-zero over zero; log and extract divide internally
   wire logic zd_det = !inv_det && (
        (op_divide && divisor_zero && !dividend_zero && !dividend_inf && !na && !nb) ||
        (REQ_OP == FXD_OP_LOG && za && !ib && !zb && !nb) ||
        (REQ_OP == FXD_OP_EXTRACT && za));
   // Extended loads never signal denormal
   wire logic den_det = !inv_det && (op_is_load ? (REQ_FMT != FXD_FMT_EXT) &&
                        is_denorm(REQ_OPA) :
                        arith && (is_denorm(REQ_OPA) || is_denorm(REQ_OPB)));

   wire logic inv_mask = ctrl_ff[`FXD_BIT_INVALID];
   wire logic zd_mask  = ctrl_ff[`FXD_BIT_ZERODIV];
   wire logic den_mask = ctrl_ff[`FXD_BIT_DENORMAL];
   // Any unmasked fault turns the request into a trap
   wire logic unmasked = (inv_det && !inv_mask) || (zd_det && !zd_mask) ||
                         (den_det && !den_mask);

   //--------------------------------------------------------------
   // Masked default results
   //--------------------------------------------------------------
   logic [79:0] mres_a;
   logic [79:0] mres_b;
   logic        mwr_a;
   logic        mwr_b;
   logic        clr_cc2;
   logic        set_unord;
   always_comb begin
      mres_a    = REQ_OPA;
      mres_b    = REQ_OPB;
      mwr_a     = 1'b0;
      mwr_b     = 1'b0;
      clr_cc2   = 1'b0;
      set_unord = 1'b0;
      if (inv_det) begin
         mwr_a = 1'b1;
         if (REQ_OP == FXD_OP_COMPARE) begin
            mwr_a     = 1'b0;
            set_unord = 1'b1;
         end else if (REQ_OP == FXD_OP_ISTORE) begin
            mres_a = {16'h0000, int_neg};
         end else if (REQ_OP == FXD_OP_BCDSTORE) begin
            mres_a = `FXD_BCD_IND;
         end else if (REQ_OP == FXD_OP_EXCHANGE) begin
            // Empty slots filled first, then swapped
            mres_a = REQ_EMPTY_B ? ind : REQ_OPB;
            mres_b = REQ_EMPTY_A ? ind : REQ_OPA;
            mwr_b  = 1'b1;
         end else if (snan_any && !unsup_any && !op_inv) begin
            // Quieted signaling NaN, A takes precedence
            mres_a = is_snan(REQ_OPA) ? REQ_OPA : REQ_OPB;
            mres_a[`FXD_QUIET_BIT] = 1'b1;
         end else begin
            mres_a  = ind;
            clr_cc2 = (REQ_OP == FXD_OP_PREM) || (REQ_OP == FXD_OP_TRIG);
         end
      end else if (zd_det) begin
         mwr_a = 1'b1;
         if (REQ_OP == FXD_OP_LOG) begin
            mres_a = inf_of(!sb);
         end else if (REQ_OP == FXD_OP_EXTRACT) begin
            mres_a = {sa, 79'h0};
            mres_b = inf_of(1'b1);
            mwr_b  = 1'b1;
         end else begin
            mres_a = inf_of(sa ^ sb);
         end
      end else if (den_det) begin
         // Continue: datapath normalizes short-format denormals on conversion
         mwr_a = 1'b0;
      end
   end

   //--------------------------------------------------------------
   // Register port decode
   //--------------------------------------------------------------
   wire logic wr_ctrl = REG_WR && (REG_ADDR == `FXD_ADDR_CTRL);
   wire logic wr_stat = REG_WR && (REG_ADDR == `FXD_ADDR_STAT);
   wire logic take    = REQ_VALID && (state_ff == FXD_ST_IDLE);
   // Newly raised flags for this request
   wire logic [15:0] raise = take ? (16'(inv_det) << `FXD_BIT_INVALID |
                                     16'(den_det) << `FXD_BIT_DENORMAL |
                                     16'(zd_det)  << `FXD_BIT_ZERODIV) : 16'h0000;
   // Condition codes altered only on masked responses
   wire logic cc_upd = take && !unmasked && (set_unord || clr_cc2);
   logic [15:0] stat_base;
   always_comb begin
      stat_base = wr_stat ? REG_WDATA : stat_ff;
      if (cc_upd) begin
         stat_base[`FXD_BIT_CC2] = set_unord;
         if (set_unord) begin
            stat_base[`FXD_BIT_CC0] = 1'b1;
            stat_base[`FXD_BIT_CC3] = 1'b1;
         end
      end
   end
   // Set wins over a software clear in the same cycle
   wire logic [15:0] nxt_stat = stat_base | raise;
   wire logic [15:0] rd_mux = (REG_ADDR == `FXD_ADDR_CTRL)  ? ctrl_ff :
                              (REG_ADDR == `FXD_ADDR_STAT)  ? stat_ff :
                              (REG_ADDR == `FXD_ADDR_CAUSE) ? {13'h0000, cause_ff} :
                              16'h0000;

   //--------------------------------------------------------------
   // Sequencer: trap lasts one cycle, then returns to idle
   //--------------------------------------------------------------
   always_comb begin
      case (state_ff)
         FXD_ST_IDLE:   nxt_state = take ? (unmasked ? FXD_ST_TRAP : FXD_ST_RESULT)
                                         : FXD_ST_IDLE;
         FXD_ST_RESULT: nxt_state = FXD_ST_IDLE;
         FXD_ST_TRAP:   nxt_state = FXD_ST_IDLE;
         default:       nxt_state = FXD_ST_IDLE;
      endcase
   end

   // Control and status state
   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         ctrl_ff  <= `FXD_CTRL_RESET; // All three faults masked at reset
         stat_ff  <= 16'h0000;
         cause_ff <= 3'h0;
         rdata_ff <= 16'h0000;
         state_ff <= FXD_ST_IDLE;
      end else if (CE) begin
         if (wr_ctrl) begin
            ctrl_ff <= REG_WDATA;
         end
         stat_ff  <= nxt_stat;
         rdata_ff <= REG_RD ? rd_mux : 16'h0000;
         state_ff <= nxt_state;
         if (take) begin
            cause_ff <= {zd_det, den_det, inv_det};
         end
      end
   end

   // Response outputs; an unmasked fault writes nothing, keeping operands
   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         rsp_valid_ff <= 1'b0;
         rsp_fault_ff <= 1'b0;
         wr_a_ff      <= 1'b0;
         wr_b_ff      <= 1'b0;
         res_a_ff     <= 80'h0;
         res_b_ff     <= 80'h0;
         trap_ff      <= 1'b0;
      end else if (CE) begin
         rsp_valid_ff <= take;
         rsp_fault_ff <= take && (inv_det || zd_det || den_det);
         wr_a_ff      <= take && !unmasked && mwr_a;
         wr_b_ff      <= take && !unmasked && mwr_b;
         trap_ff      <= take && unmasked;
         if (take) begin
            res_a_ff <= mres_a;
            res_b_ff <= mres_b;
         end
      end
   end

   assign REG_RDATA    = rdata_ff;
   assign RSP_VALID    = rsp_valid_ff;
   assign RSP_FAULT    = rsp_fault_ff;
   assign RSP_WRITE_A  = wr_a_ff;
   assign RSP_WRITE_B  = wr_b_ff;
   assign RSP_RES_A    = res_a_ff;
   assign RSP_RES_B    = res_b_ff;
   assign TRAP         = trap_ff;
   assign STATUS_WORD  = stat_ff;
   assign CONTROL_WORD = ctrl_ff;
endmodule

//--- testbench/fxd_exception_unit_chk.sv
`timescale 1ns/100ps
`include "fxd_defines.svh"
// ----------------------------------------------------------------
// Port-level checker for the operand exception unit
// ----------------------------------------------------------------
module fxd_exception_unit_chk
   import fxd_pkg::*;
(
   input wire logic                 MCLK,
   input wire logic                 RESETN,
   input wire logic                 REQ_VALID,
   input wire fxd_pkg::fxd_op_type  REQ_OP,
   input wire logic [1:0]           REG_ADDR,
   input wire logic                 REG_WR,
   input wire logic                 RSP_VALID,
   input wire logic                 RSP_FAULT,
   input wire logic                 RSP_WRITE_A,
   input wire logic                 RSP_WRITE_B,
   input wire logic [79:0]          RSP_RES_A,
   input wire logic [79:0]          RSP_RES_B,
   input wire logic                 TRAP,
   input wire logic [15:0]          STATUS_WORD,
   input wire logic [15:0]          CONTROL_WORD
);
   // One domain, so clock and reset are given once
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RESETN);

   // Patterns the masked responses must produce
   wire logic [79:0] real_ind = {`FXD_IND_HI, `FXD_IND_LO};
   wire logic [78:0] inf_mag  = {`FXD_EXP_ONES, `FXD_INF_LO};
   // Status write strobe, the only way software may drop a flag
   wire logic        stat_wr  = REG_WR && (REG_ADDR == `FXD_ADDR_STAT);

   trap_no_write_a: assert property (TRAP |-> RSP_VALID && RSP_FAULT && !RSP_WRITE_A && !RSP_WRITE_B)
      else $error("trap came with a register write");
   trap_unmasked_a: assert property (TRAP |-> (STATUS_WORD[2:0] & ~$past(CONTROL_WORD[2:0])) != 3'h0)
      else $error("trap without an unmasked flag");
   flags_sticky_a: assert property (!$past(stat_wr) |-> ($past(STATUS_WORD[2:0]) & ~STATUS_WORD[2:0]) == 3'h0)
      else $error("exception flag dropped by hardware");
   indef_inv_a: assert property (RSP_VALID && RSP_FAULT && RSP_WRITE_A && RSP_RES_A == real_ind |-> STATUS_WORD[0])
      else $error("indefinite written without invalid flag");
   inf_zdiv_a: assert property (RSP_VALID && RSP_FAULT && RSP_WRITE_A && !RSP_WRITE_B &&
      RSP_RES_A[78:0] == inf_mag |-> STATUS_WORD[2])
      else $error("infinity written without zero-divide flag");
   cmp_unordered_a: assert property ($past(REQ_VALID && REQ_OP == FXD_OP_COMPARE)
      && RSP_VALID && RSP_FAULT && !TRAP && STATUS_WORD[0] && !$past(STATUS_WORD[0])
      |-> STATUS_WORD[14] && STATUS_WORD[10] && STATUS_WORD[8])
      else $error("unordered compare codes not 111");
   c2_cleared_a: assert property (RSP_VALID && RSP_FAULT && !TRAP && RSP_WRITE_A
      && $past(REQ_VALID && (REQ_OP == FXD_OP_PREM || REQ_OP == FXD_OP_TRIG))
      && RSP_RES_A == real_ind |-> !STATUS_WORD[10])
      else $error("condition bit two left set");
   extract_pair_a: assert property ($past(REQ_VALID && REQ_OP == FXD_OP_EXTRACT)
      && RSP_VALID && !TRAP && STATUS_WORD[2] && !$past(STATUS_WORD[2])
      |-> RSP_WRITE_A && RSP_WRITE_B && RSP_RES_B == {1'b1, inf_mag} && RSP_RES_A[78:0] == 79'h0)
      else $error("extract zero-divide pair wrong");
   rsp_single_a: assert property (RSP_VALID |-> $past(REQ_VALID) ##1 !RSP_VALID)
      else $error("response not a single pulse after a request");
endmodule
bind fxd_exception_unit fxd_exception_unit_chk u_chk (.MCLK(MCLK), .RESETN(RESETN),
   .REQ_VALID(REQ_VALID), .REQ_OP(REQ_OP), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
   .RSP_VALID(RSP_VALID), .RSP_FAULT(RSP_FAULT), .RSP_WRITE_A(RSP_WRITE_A),
   .RSP_WRITE_B(RSP_WRITE_B), .RSP_RES_A(RSP_RES_A), .RSP_RES_B(RSP_RES_B), .TRAP(TRAP),
   .STATUS_WORD(STATUS_WORD), .CONTROL_WORD(CONTROL_WORD));

//--- testbench/tb_fxd_exception_unit.sv
`timescale 1ns/100ps
`include "fxd_defines.svh"
// ----------------------------------------------------------------
// Directed bench: each request is run against a preset status word
// ----------------------------------------------------------------
module tb_fxd_exception_unit;
   import fxd_pkg::*;
   localparam logic [79:0] IND  = {`FXD_IND_HI, `FXD_IND_LO};
   localparam logic [79:0] ONE  = 80'h3fff_8000_0000_0000_0000;
   localparam logic [79:0] PINF = 80'h7fff_8000_0000_0000_0000;
   localparam logic [79:0] NINF = 80'hffff_8000_0000_0000_0000;
   localparam logic [79:0] NZER = 80'h8000_0000_0000_0000_0000;
   localparam logic [79:0] NTWO = 80'hc000_8000_0000_0000_0000;
   localparam logic [79:0] SNAN = 80'h7fff_a000_0000_0000_0000;
   localparam logic [79:0] QNAN = 80'h7fff_e000_0000_0000_0000;
   localparam logic [79:0] DEN  = 80'h0000_0000_0000_0000_0001;
   localparam logic [79:0] UNS  = 80'h3fff_4000_0000_0000_0000;
   logic MCLK = 1'b0, RESETN = 1'b0, REQ_VALID = 1'b0, REQ_EMPTY_A = 1'b0, REQ_EMPTY_B = 1'b0;
   logic REG_WR = 1'b0, REG_RD = 1'b0, RSP_VALID, RSP_FAULT, RSP_WRITE_A, RSP_WRITE_B, TRAP;
   fxd_op_type  REQ_OP = FXD_OP_ADD;
   fxd_isz_type REQ_ISZ = FXD_INT_16;
   fxd_fmt_type REQ_FMT = FXD_FMT_EXT;
   logic [79:0] REQ_OPA = 80'h0, REQ_OPB = 80'h0, RSP_RES_A, RSP_RES_B;
   logic [1:0]  REG_ADDR = 2'h0;
   logic [15:0] REG_WDATA = 16'h0, REG_RDATA, STATUS_WORD, CONTROL_WORD;
   int          miscompares = 0, n_checks = 0;
   // Invalid cases whose masked answer is the real indefinite
   fxd_op_type  iop[12] = '{FXD_OP_ADD, FXD_OP_SUB, FXD_OP_MUL, FXD_OP_MUL, FXD_OP_DIV,
      FXD_OP_DIV, FXD_OP_ADD, FXD_OP_SQRT, FXD_OP_LOG, FXD_OP_LOGP1, FXD_OP_TRIG, FXD_OP_PREM};
   logic [79:0] ia[12] = '{PINF, PINF, PINF, 80'h0, PINF, 80'h0, UNS, NTWO, NTWO, NTWO, PINF, PINF};
   logic [79:0] ib[12] = '{NINF, PINF, 80'h0, PINF, NINF, 80'h0, ONE, 80'h0, ONE, ONE, 80'h0, ONE};
   logic [14:0] iexp[3] = '{`FXD_INT16_EXP, `FXD_INT32_EXP, `FXD_INT64_EXP};
   logic [63:0] ineg[3] = '{`FXD_INT16_NEG, `FXD_INT32_NEG, `FXD_INT64_NEG};

   fxd_exception_unit uut (.MCLK(MCLK), .RESETN(RESETN), .CE(1'b1), .REQ_VALID(REQ_VALID),
      .REQ_OP(REQ_OP), .REQ_FMT(REQ_FMT), .REQ_ISZ(REQ_ISZ), .REQ_OPA(REQ_OPA),
      .REQ_OPB(REQ_OPB), .REQ_EMPTY_A(REQ_EMPTY_A), .REQ_EMPTY_B(REQ_EMPTY_B),
      .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
      .REG_RDATA(REG_RDATA), .RSP_VALID(RSP_VALID), .RSP_FAULT(RSP_FAULT),
      .RSP_WRITE_A(RSP_WRITE_A), .RSP_WRITE_B(RSP_WRITE_B), .RSP_RES_A(RSP_RES_A),
      .RSP_RES_B(RSP_RES_B), .TRAP(TRAP), .STATUS_WORD(STATUS_WORD),
      .CONTROL_WORD(CONTROL_WORD));

   // 200 MHz core clock
   always #2.5 MCLK = ~MCLK;

   // ----------------------------------------------------------------
   // Compare and access tasks
   // ----------------------------------------------------------------
   task automatic chk_bit(input string nm, input logic e, input logic g);
      n_checks++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
      end
   endtask
   task automatic chk_word(input string nm, input logic [79:0] e, input logic [79:0] g);
      n_checks++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Single-cycle register write, strobe dropped at the next edge
   task automatic wr(input logic [1:0] a, input logic [15:0] d);
      @(posedge MCLK);
      REG_WR <= 1'b1;
      REG_ADDR <= a;
      REG_WDATA <= d;
      @(posedge MCLK);
      REG_WR <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [1:0] a, input logic [15:0] e);
      @(posedge MCLK);
      REG_RD <= 1'b1;
      REG_ADDR <= a;
      @(posedge MCLK);
      REG_RD <= 1'b0;
      #1;
      chk_word("read data", 80'(e), 80'(REG_RDATA));
   endtask
   // One request after presetting status; the answer is looked at in its only cycle
   task automatic t(input fxd_op_type op, input logic [79:0] a, b, input logic ea,
      input fxd_isz_type isz, input logic [15:0] sw0, input logic [2:0] fl,
      input logic flt, trp, wa, input logic [79:0] ra);
      wr(`FXD_ADDR_STAT, sw0);
      @(posedge MCLK);
      REQ_VALID <= 1'b1;
      REQ_OP <= op;
      REQ_OPA <= a;
      REQ_OPB <= b;
      REQ_EMPTY_A <= ea;
      REQ_ISZ <= isz;
      @(posedge MCLK);
      REQ_VALID <= 1'b0;
      #1;
      chk_bit("valid", 1'b1, RSP_VALID);
      chk_bit("fault", flt, RSP_FAULT);
      chk_bit("trap", trp, TRAP);
      chk_bit("write a", wa, RSP_WRITE_A);
      chk_word("flags", 80'(fl), 80'(STATUS_WORD[2:0]));
      // Integer stores carry the value in the low 64 bits only
      if (wa)
         chk_word("result", ra, (op == FXD_OP_ISTORE) ? {16'h0, RSP_RES_A[63:0]} : RSP_RES_A);
   endtask
   task automatic conclude();
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Watchdog: the sequence needs well under a thousand cycles
   // ----------------------------------------------------------------
   initial begin
      #20000;
      miscompares++;
      conclude();
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (12) @(posedge MCLK);
      RESETN <= 1'b1;
      rd(2'h3, 16'h0000);
      rd(`FXD_ADDR_CTRL, 16'h0007);
      #5 chk_word("idle read data", 80'h0, 80'(REG_RDATA));
      foreach (iop[i]) t(iop[i], ia[i], ib[i], 1'b0, FXD_INT_16, 16'h0, 3'h1, 1, 0, 1, IND);
      t(FXD_OP_ADD, SNAN, ONE, 1'b0, FXD_INT_16, 16'h0, 3'h1, 1, 0, 1, QNAN);
      t(FXD_OP_COMPARE, SNAN, ONE, 1'b0, FXD_INT_16, 16'h0, 3'h1, 1, 0, 0, IND);
      chk_word("codes", 80'h7, 80'({STATUS_WORD[14], STATUS_WORD[10], STATUS_WORD[8]}));
      t(FXD_OP_TRIG, PINF, 80'h0, 1'b0, FXD_INT_16, 16'h0400, 3'h1, 1, 0, 1, IND);
      chk_bit("condition two", 1'b0, STATUS_WORD[10]);
      for (int k = 0; k < 3; k++)
         t(FXD_OP_ISTORE, {1'b0, iexp[k], `FXD_INF_LO}, 80'h0, 1'b0, fxd_isz_type'(k),
            16'h0, 3'h1, 1, 0, 1, {16'h0, ineg[k]});
      t(FXD_OP_BCDSTORE, ONE, 80'h0, 1'b1, FXD_INT_16, 16'h0, 3'h1, 1, 0, 1, `FXD_BCD_IND);
      t(FXD_OP_BCDSTORE, QNAN, 80'h0, 1'b0, FXD_INT_16, 16'h0, 3'h1, 1, 0, 1, `FXD_BCD_IND);
      t(FXD_OP_BCDSTORE, 80'h403b_8000_0000_0000_0000, 80'h0, 1'b0, FXD_INT_16, 16'h0, 3'h1,
         1, 0, 1, `FXD_BCD_IND);
      t(FXD_OP_EXCHANGE, ONE, ONE, 1'b1, FXD_INT_16, 16'h0, 3'h1, 1, 0, 1, ONE);
      chk_word("exchange b", IND, RSP_RES_B);
      REQ_EMPTY_B <= 1'b1;
      t(FXD_OP_EXCHANGE, NTWO, ONE, 1'b0, FXD_INT_16, 16'h0, 3'h1, 1, 0, 1, IND);
      chk_word("exchange b", NTWO, RSP_RES_B);
      REQ_EMPTY_B <= 1'b0;
      t(FXD_OP_SQRT, NZER, 80'h0, 1'b0, FXD_INT_16, 16'h0, 3'h0, 0, 0, 0, NZER);
      t(FXD_OP_DIV, NTWO, 80'h0, 1'b0, FXD_INT_16, 16'h0, 3'h4, 1, 0, 1, NINF);
      t(FXD_OP_RDIV, 80'h0, ONE, 1'b0, FXD_INT_16, 16'h0, 3'h4, 1, 0, 1, PINF);
      t(FXD_OP_LOG, 80'h0, ONE, 1'b0, FXD_INT_16, 16'h0, 3'h4, 1, 0, 1, NINF);
      t(FXD_OP_EXTRACT, NZER, 80'h0, 1'b0, FXD_INT_16, 16'h0, 3'h4, 1, 0, 1, NZER);
      chk_bit("extract write b", 1'b1, RSP_WRITE_B);
      chk_word("extract b", NINF, RSP_RES_B);
      t(FXD_OP_ADD, DEN, ONE, 1'b0, FXD_INT_16, 16'h0, 3'h2, 1, 0, 0, IND);
      t(FXD_OP_LOAD, DEN, 80'h0, 1'b0, FXD_INT_16, 16'h0, 3'h0, 0, 0, 0, DEN);
      REQ_FMT <= FXD_FMT_SINGLE;
      t(FXD_OP_LOAD, DEN, 80'h0, 1'b0, FXD_INT_16, 16'h0, 3'h2, 1, 0, 0, DEN);
      REQ_FMT <= FXD_FMT_EXT;
      t(FXD_OP_LOAD, ONE, 80'h0, 1'b0, FXD_INT_16, 16'h0007, 3'h7, 0, 0, 0, ONE);
      wr(`FXD_ADDR_CTRL, 16'h0006);
      t(FXD_OP_ADD, PINF, NINF, 1'b0, FXD_INT_16, 16'h0, 3'h1, 1, 1, 0, IND);
      wr(`FXD_ADDR_CTRL, 16'h0003);
      t(FXD_OP_DIV, ONE, 80'h0, 1'b0, FXD_INT_16, 16'h0, 3'h4, 1, 1, 0, IND);
      wr(`FXD_ADDR_CTRL, 16'h0005);
      t(FXD_OP_ADD, DEN, ONE, 1'b0, FXD_INT_16, 16'h0, 3'h2, 1, 1, 0, IND);
      rd(`FXD_ADDR_STAT, 16'h0002);
      wr(`FXD_ADDR_STAT, 16'h0000);
      rd(`FXD_ADDR_STAT, 16'h0000);
      conclude();
   end
endmodule
